// >>> src/csp_defs.svh
// constants of the codec serial frame port: frame timing, serial command
// layout, control register map and bus register offsets
// assumes inclusion by bare name from the package and the design module
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// frame timing, counted in codec master clocks and shift clocks
`define CSP_FRAME_DIV 512
`define CSP_SCLK_DIV 2
`define CSP_SCLKS_PER_FRAME (`CSP_FRAME_DIV / `CSP_SCLK_DIV)
`define CSP_WORD_BITS 16
`define CSP_PRI_SYNC 8'h00
`define CSP_PRI_START 8'h01
`define CSP_SEC_SYNC 8'h80
`define CSP_SEC_START 8'h81
`define CSP_POS_LAST 4'hF
`define CSP_POS_ADDR_DONE 4'h7

// secondary command word layout
`define CSP_CMD_RD_BIT 13
`define CSP_CMD_ADDR_MSB 12
`define CSP_CMD_ADDR_LSB 8
`define CSP_CMD_DATA_MSB 7

// serial control registers
`define CSP_CREG_NONE 5'h00
`define CSP_CREG_1 5'h01
`define CSP_CREG_2 5'h02
`define CSP_CREG1_RST 8'h00
`define CSP_CREG2_RST 7'h00
`define CSP_OVF_BIT 0

// bus register byte offsets
`define CSP_A_CTRL 8'h00
`define CSP_A_STATUS 8'h04
`define CSP_A_DIN 8'h08
`define CSP_A_FCNT 8'h0C
`define CSP_CTRL_EN_BIT 0

`endif

// >>> src/csp_pkg.sv
// types shared by the codec serial frame port
// assumes csp_defs.svh is reachable on the include path
`include "csp_defs.svh"

package csp_pkg;
    // which part of the frame the current shift clock period belongs to
    typedef enum logic [1:0] {
        SLOT_GAP,
        SLOT_PRI,
        SLOT_SEC
    } csp_slot_e;

    typedef logic [`CSP_WORD_BITS-1:0] csp_word_t;
endpackage

// >>> src/csp_frame_port.sv
// codec serial frame port, device end: frame sync, shift clock, primary
// sample words, secondary control words, plus an AHB-Lite status slave
// assumes mclk is the codec master clock and all inputs are synchronous to it
//
// What this block does
// - primary input word: DAC in D15..D1, request D0
// - every serial word goes MSB first
// - ADC output word is 16 bits, D15 MSB
// - samples are two's complement, passed unchanged
// - pulse mode: sync high one shift clock
// - primary frame moves one word each way
// - envelope mode: sync low for whole word
// - device itself drives envelope sync low
// - envelope sync returns high after sixteen bits
// - control registers change only in secondary frames, bar the overflow flag, which sets at any time
// - register zero command changes nothing
// - secondary write returns all zeros on output
// - input D0 set requests a secondary frame
// - pulse mode: second sync 128 clocks later
// - secondary word starts one period after sync
// - envelope mode: secondary opens 128 clocks later
// - first bit with falling edge of sync
// - control registers reachable only over serial
// - frame is master clock divided by 512
// - overflow flag cleared only by serial read
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "csp_defs.svh"

module csp_frame_port
    import csp_pkg::*;
#(
    parameter int FRAME_SCLKS = `CSP_SCLKS_PER_FRAME
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic shiftClock,
    output logic frameSync,
    output logic serialDataOut,
    input wire logic serialDataIn,
    input wire logic syncModeStrap,
    input wire logic [15:0] adcSample,
    input wire logic adcFullScale,
    output logic [14:0] dacSample,
    output logic dacStrobe,
    output logic [7:0] ctrlReg1,
    output logic [7:0] ctrlReg2
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic enable_reg;
    logic phase_reg;
    logic [7:0] sclkIdx_reg;
    logic pulseMode_reg;
    logic secReq_reg;
    csp_word_t txWord_reg;
    csp_word_t rxShift_reg;
    logic [7:0] cr1_reg;
    logic [6:0] cr2Hi_reg;
    logic overflow_reg;
    logic [15:0] lastDin_reg;
    logic [15:0] frameCnt_reg;
    logic shiftClock_reg;
    logic frameSync_reg;
    logic dout_reg;
    logic [14:0] dacSample_reg;
    logic dacStrobe_reg;
    logic [31:0] hrdata_reg;
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // true while idx lies in the sixteen shift clocks that start at first
    function automatic logic inWord(input logic [7:0] idx, input logic [7:0] first);
        logic [7:0] rel;
        rel = idx - first;
        return rel < 8'(`CSP_WORD_BITS);
    endfunction

    // value a secondary read returns for a given register address
    function automatic logic [7:0] cregValue(input logic [4:0] addr, input logic [7:0] r1,
                                             input logic [7:0] r2);
        logic [7:0] v;
        v = 8'h00;
        if (addr == `CSP_CREG_1) begin
            v = r1;
        end else if (addr == `CSP_CREG_2) begin
            v = r2;
        end
        return v;
    endfunction

    // ---------------------------------------------------------------
    // frame position decode
    // ---------------------------------------------------------------
    csp_slot_e slot;
    logic [3:0] bitPos;
    logic riseTick;
    logic fallTick;
    logic [7:0] cr2Full;
    csp_word_t fullWord;
    logic [7:0] cmdHigh;
    logic cmdRead;
    logic [4:0] cmdAddr;
    logic wordEnd;
    logic addrDone;

    // secondary slot exists only when the last primary word asked for it
    always_comb begin
        if (inWord(sclkIdx_reg, `CSP_PRI_START)) begin
            slot = SLOT_PRI;
        end else if (secReq_reg && inWord(sclkIdx_reg, `CSP_SEC_START)) begin
            slot = SLOT_SEC;
        end else begin
            slot = SLOT_GAP;
        end
    end

    assign bitPos = (slot == SLOT_SEC) ? 4'(sclkIdx_reg - `CSP_SEC_START)
                                       : 4'(sclkIdx_reg - `CSP_PRI_START);
    // rising shift clock follows the phase-0 edge, sampling uses phase 1
    assign riseTick = enable_reg && !phase_reg;
    assign fallTick = enable_reg && phase_reg;
    assign cr2Full = {cr2Hi_reg, overflow_reg};
    // incoming word including the bit on the line right now
    assign fullWord = {rxShift_reg[14:0], serialDataIn};
    assign cmdHigh = {rxShift_reg[6:0], serialDataIn};
    assign cmdRead = cmdHigh[`CSP_CMD_RD_BIT - `CSP_CMD_ADDR_LSB];
    assign cmdAddr = cmdHigh[4:0];
    assign wordEnd = fallTick && (slot != SLOT_GAP) && (bitPos == `CSP_POS_LAST);
    assign addrDone = fallTick && (slot == SLOT_SEC) && (bitPos == `CSP_POS_ADDR_DONE);

    // ---------------------------------------------------------------
    // shift clock divider and frame counter
    // ---------------------------------------------------------------
    // two master clocks per shift clock, FRAME_SCLKS per frame
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= 1'b0;
            sclkIdx_reg <= 8'h00;
        end else if (!enable_reg) begin
            phase_reg <= 1'b0;
            sclkIdx_reg <= 8'h00;
        end else begin
            phase_reg <= !phase_reg;
            if (phase_reg) begin
                if (sclkIdx_reg == 8'(FRAME_SCLKS - 1)) begin
                    sclkIdx_reg <= 8'h00;
                end else begin
                    sclkIdx_reg <= sclkIdx_reg + 8'h01;
                end
            end
        end
    end

    // shift clock pin, parked low while the port is stopped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shiftClock_reg <= 1'b0;
        end else begin
            shiftClock_reg <= riseTick;
        end
    end

    // strap is sampled while stopped and at each frame start, never mid frame
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pulseMode_reg <= 1'b1;
        end else if (!enable_reg || (riseTick && sclkIdx_reg == `CSP_PRI_SYNC)) begin
            pulseMode_reg <= syncModeStrap;
        end
    end

    // frames started, counted at each frame start, for software to watch progress
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            frameCnt_reg <= 16'h0000;
        end else if (riseTick && sclkIdx_reg == `CSP_PRI_SYNC) begin
            frameCnt_reg <= frameCnt_reg + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // frame sync
    // ---------------------------------------------------------------
    // decided with the mode that holds at this edge; the strap update at
    // frame start lands one edge later, so sync of slot 0 uses the old mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            frameSync_reg <= 1'b0;
        end else if (!enable_reg) begin
            frameSync_reg <= !pulseMode_reg;
        end else if (riseTick) begin
            if (pulseMode_reg) begin
                // one shift clock high, word begins as it falls
                frameSync_reg <= (sclkIdx_reg == `CSP_PRI_SYNC) ||
                                 (secReq_reg && sclkIdx_reg == `CSP_SEC_SYNC);
            end else begin
                // low across the word, high again after the last bit
                frameSync_reg <= (slot == SLOT_GAP);
            end
        end
    end

    // ---------------------------------------------------------------
    // transmit side
    // ---------------------------------------------------------------
    // read data is patched into the low byte once the address is known,
    // which is why the word is indexed rather than shifted
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            txWord_reg <= '0;
        end else if (riseTick && sclkIdx_reg == `CSP_PRI_SYNC) begin
            txWord_reg <= adcSample;
        end else if (riseTick && sclkIdx_reg == `CSP_SEC_SYNC) begin
            txWord_reg <= '0;
        end else if (addrDone && cmdRead) begin
            txWord_reg[`CSP_CMD_DATA_MSB:0] <= cregValue(cmdAddr, cr1_reg, cr2Full);
        end
    end

    // data pin changes with the rising shift clock, zero between words
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dout_reg <= 1'b0;
        end else if (!enable_reg) begin
            dout_reg <= 1'b0;
        end else if (riseTick) begin
            if (slot != SLOT_GAP) begin
                dout_reg <= txWord_reg[4'hF - bitPos];
            end else begin
                dout_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // receive side
    // ---------------------------------------------------------------
    // sampled at the falling shift clock, mid bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rxShift_reg <= '0;
        end else if (fallTick && slot != SLOT_GAP) begin
            rxShift_reg <= fullWord;
        end
    end

    // primary word end: sample to the DAC, D0 is the request flag
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dacSample_reg <= '0;
            dacStrobe_reg <= 1'b0;
            lastDin_reg <= 16'h0000;
        end else begin
            dacStrobe_reg <= 1'b0;
            if (wordEnd && slot == SLOT_PRI) begin
                dacSample_reg <= fullWord[15:1];
                dacStrobe_reg <= 1'b1;
                lastDin_reg <= fullWord;
            end
        end
    end

    // request holds until the next primary sync, so a missed one is not kept
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            secReq_reg <= 1'b0;
        end else if (!enable_reg) begin
            secReq_reg <= 1'b0;
        end else if (wordEnd && slot == SLOT_PRI) begin
            secReq_reg <= fullWord[0];
        end else if (riseTick && sclkIdx_reg == `CSP_PRI_SYNC) begin
            secReq_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // serial control registers
    // ---------------------------------------------------------------
    // written only at the end of a secondary write word, never from the bus
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cr1_reg <= `CSP_CREG1_RST;
            cr2Hi_reg <= `CSP_CREG2_RST;
        end else if (wordEnd && slot == SLOT_SEC && !fullWord[`CSP_CMD_RD_BIT]) begin
            if (fullWord[`CSP_CMD_ADDR_MSB:`CSP_CMD_ADDR_LSB] == `CSP_CREG_1) begin
                cr1_reg <= fullWord[`CSP_CMD_DATA_MSB:0];
            end else if (fullWord[`CSP_CMD_ADDR_MSB:`CSP_CMD_ADDR_LSB] == `CSP_CREG_2) begin
                cr2Hi_reg <= fullWord[`CSP_CMD_DATA_MSB:1];
            end
            // no_operation_command and unknown addresses fall through untouched
        end
    end

    // overflow is sticky; a new full-scale event beats the read clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            overflow_reg <= 1'b0;
        end else if (adcFullScale) begin
            overflow_reg <= 1'b1;
        end else if (addrDone && cmdRead && cmdAddr == `CSP_CREG_2) begin
            overflow_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ---------------------------------------------------------------
    logic addrPhase;
    logic [31:0] readMux;

    assign addrPhase = hsel && hready && htrans[1];

    // unmapped offsets read as zero
    always_comb begin
        readMux = 32'h0000_0000;
        case (haddr[7:0])
            `CSP_A_CTRL: readMux = {31'h0000_0000, enable_reg};
            `CSP_A_STATUS: readMux = {16'h0000, sclkIdx_reg, 6'h00, pulseMode_reg, secReq_reg};
            `CSP_A_DIN: readMux = {16'h0000, lastDin_reg};
            `CSP_A_FCNT: readMux = {16'h0000, frameCnt_reg};
            default: readMux = 32'h0000_0000;
        endcase
    end

    // address phase capture; read data registered for the data phase
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            if (hready) begin
                wrPend_reg <= addrPhase && hwrite;
                wrAddr_reg <= haddr[7:0];
            end
            if (addrPhase && !hwrite) begin
                hrdata_reg <= readMux;
            end
        end
    end

    // port enable is the only writable bus bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enable_reg <= 1'b0;
        end else if (wrPend_reg && wrAddr_reg == `CSP_A_CTRL) begin
            enable_reg <= hwdata[`CSP_CTRL_EN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign shiftClock = shiftClock_reg;
    assign frameSync = frameSync_reg;
    assign serialDataOut = dout_reg;
    assign dacSample = dacSample_reg;
    assign dacStrobe = dacStrobe_reg;
    assign ctrlReg1 = cr1_reg;
    assign ctrlReg2 = cr2Full;

endmodule
`default_nettype wire

// >>> verification/csp_frame_port_properties.sv
// assertion checker for the codec serial frame port, bound to its top
// assumes one mclk domain and a strap that only changes under reset
`timescale 1ns/10ps
`default_nettype none
module csp_frame_port_checker #(
    parameter int FRAME_SCLKS = 256
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic shiftClock,
    input wire logic frameSync,
    input wire logic serialDataOut,
    input wire logic syncModeStrap,
    input wire logic adcFullScale,
    input wire logic dacStrobe,
    input wire logic [7:0] ctrlReg1,
    input wire logic [7:0] ctrlReg2
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ----------------
    // frame event tracking
    // ----------------
    logic fsPrev;
    logic seen;
    logic secFlag;
    logic evt;
    logic [9:0] sinceEvt;
    logic [5:0] lowCnt;
    // an event is the sync edge that opens a word in the strapped mode
    assign evt = syncModeStrap ? (frameSync & ~fsPrev) : (~frameSync & fsPrev);
    // distance counter saturates so a stopped port never wraps into a match
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fsPrev <= 1'b0;
            seen <= 1'b0;
            secFlag <= 1'b0;
            sinceEvt <= 10'h000;
            lowCnt <= 6'h00;
        end else begin
            fsPrev <= frameSync;
            lowCnt <= frameSync ? 6'h00 : lowCnt + 6'h01;
            if (evt) begin
                sinceEvt <= 10'h001;
                seen <= 1'b1;
                // the primary after a secondary is also half a frame on
                secFlag <= seen && !secFlag && (sinceEvt == 10'h100);
            end else if (sinceEvt != 10'h3FF) begin
                sinceEvt <= sinceEvt + 10'h001;
            end
        end
    end
    // ----------------
    // properties
    // ----------------
    a_pulse_width: assert property (
        syncModeStrap && $rose(frameSync) |-> frameSync [*2] ##1 !frameSync)
        else $error("pulse sync not one shift clock wide");
    a_env_word_len: assert property (
        !syncModeStrap && frameSync && !fsPrev && seen |-> lowCnt == 6'h20)
        else $error("envelope sync low time not sixteen bits");
    a_frame_spacing: assert property (
        evt && seen |-> (sinceEvt == 10'h100) || (sinceEvt == 2 * FRAME_SCLKS))
        else $error("sync event at wrong distance");
    a_sync_on_sclk: assert property (
        syncModeStrap && $rose(frameSync) |-> $rose(shiftClock))
        else $error("sync edge off the rising shift clock");
    a_data_on_sclk: assert property (
        $changed(serialDataOut) |-> $rose(shiftClock))
        else $error("output bit changed off the rising shift clock");
    a_reg1_in_sec: assert property (
        $changed(ctrlReg1) |-> secFlag && sinceEvt inside {[28:40]})
        else $error("control register 1 changed outside a secondary word");
    a_reg2_in_sec: assert property (
        $changed(ctrlReg2[7:1]) |-> secFlag && sinceEvt inside {[28:40]})
        else $error("control register 2 changed outside a secondary word");
    a_ovf_set: assert property (
        adcFullScale |-> ##[1:2] ctrlReg2[0])
        else $error("overflow flag not set");
    a_ovf_clear: assert property (
        $fell(ctrlReg2[0]) |-> secFlag && sinceEvt inside {[15:17]})
        else $error("overflow flag cleared outside a secondary read");
    a_strobe_pulse: assert property (
        dacStrobe |=> !dacStrobe [*8])
        else $error("sample strobe longer than one cycle");
    c_secondary: cover property (evt && seen && sinceEvt == 10'h100);
    c_reg1_write: cover property ($changed(ctrlReg1));
    c_ovf_clear: cover property ($fell(ctrlReg2[0]));
endmodule

bind csp_frame_port csp_frame_port_checker #(.FRAME_SCLKS(FRAME_SCLKS)) csp_frame_port_checker_i (
    .mclk, .rstn, .shiftClock, .frameSync, .serialDataOut, .syncModeStrap,
    .adcFullScale, .dacStrobe, .ctrlReg1, .ctrlReg2
);
`default_nettype wire

// >>> verification/csp_host_model.sv
// host serial port model: follows the device's shift clock and sync
// assumes the strap is steady while words move
`timescale 1ns/10ps
`default_nettype none
module csp_host_model (
    input wire logic shiftClock,
    input wire logic frameSync,
    input wire logic serialDataOut,
    input wire logic syncModeStrap,
    input wire logic [15:0] priWord,
    input wire logic [15:0] secWord,
    output logic serialDataIn,
    output logic [15:0] rxPri,
    output logic [15:0] rxSec,
    output logic [7:0] priCnt,
    output logic [7:0] secCnt
);
    logic [15:0] txSh;
    logic [15:0] rxSh;
    logic fsPrev = 1'b1;
    logic pend = 1'b0;
    logic active = 1'b0;
    logic isSec = 1'b0;
    logic start;
    int pos = 0;
    int sinceStart = 0;
    initial begin
        serialDataIn = 1'b0;
        rxPri = 16'h0000;
        rxSec = 16'h0000;
        priCnt = 8'h00;
        secCnt = 8'h00;
    end
    // ----------------
    // drive side, just after each rising shift clock
    // ----------------
    // a word only counts as secondary when it opens 128 clocks after a primary
    always @(posedge shiftClock) begin
        #1;
        sinceStart = sinceStart + 1;
        start = syncModeStrap ? pend : (!frameSync && fsPrev);
        pend = syncModeStrap && frameSync;
        fsPrev = frameSync;
        if (start) begin
            isSec = (sinceStart == 128);
            if (!isSec) sinceStart = 0;
            txSh = isSec ? secWord : priWord;
            pos = 15;
            active = 1'b1;
            serialDataIn = txSh[15];
        end else if (active && pos > 0) begin
            pos = pos - 1;
            serialDataIn = txSh[pos];
        end else begin
            serialDataIn = ~serialDataIn; // idle line carries no stale bit
        end
    end
    // capture side, mid period on the falling shift clock
    always @(negedge shiftClock) begin
        if (active) begin
            rxSh = {rxSh[14:0], serialDataOut};
            if (pos == 0) begin
                active = 1'b0;
                if (isSec) begin
                    rxSec = rxSh;
                    secCnt = secCnt + 8'h01;
                end else begin
                    rxPri = rxSh;
                    priCnt = priCnt + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/csp_frame_port_tb.sv
// self-checking bench: bus master, host model and frame scenarios
// assumes the checker binds itself to the port under test
`timescale 1ns/10ps
`default_nettype none
module csp_frame_port_tb;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic syncModeStrap = 1'b1;
    logic [15:0] adcSample = 16'h0000;
    logic adcFullScale = 1'b0;
    logic [15:0] priWord = 16'h0000;
    logic [15:0] secWord = 16'h0000;
    logic hreadyout, hresp, shiftClock, frameSync, serialDataOut, serialDataIn, dacStrobe;
    logic [31:0] hrdata, d;
    logic [14:0] dacSample;
    logic [7:0] ctrlReg1, ctrlReg2, priCnt, secCnt, sc;
    logic [15:0] rxPri, rxSec, rx;
    int miscompares = 0;
    int totalChecks = 0;
    logic [7:0] strobeCnt = 8'h00;
    logic [15:0] cmdTab [5] = '{16'h013C, 16'h2100, 16'h02FE, 16'h00FF, 16'h2200};
    logic [15:0] rxTab [5] = '{16'h0000, 16'h003C, 16'h0000, 16'h0000, 16'h00FF};
    logic [7:0] r2Tab [5] = '{8'h00, 8'h00, 8'hFE, 8'hFF, 8'hFE};

    always #25 mclk = ~mclk;

    // strobes counted mid cycle, where the registered pulse has settled
    always @(negedge mclk) begin
        if (dacStrobe === 1'b1) strobeCnt <= strobeCnt + 8'h01;
    end

    csp_frame_port csp_frame_port_i (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .shiftClock(shiftClock),
        .frameSync(frameSync), .serialDataOut(serialDataOut), .serialDataIn(serialDataIn),
        .syncModeStrap(syncModeStrap), .adcSample(adcSample), .adcFullScale(adcFullScale),
        .dacSample(dacSample), .dacStrobe(dacStrobe), .ctrlReg1(ctrlReg1), .ctrlReg2(ctrlReg2)
    );
    csp_host_model csp_host_model_i (
        .shiftClock(shiftClock), .frameSync(frameSync), .serialDataOut(serialDataOut),
        .syncModeStrap(syncModeStrap), .priWord(priWord), .secWord(secWord),
        .serialDataIn(serialDataIn), .rxPri(rxPri), .rxSec(rxSec), .priCnt(priCnt),
        .secCnt(secCnt)
    );
    // ----------------
    // shared tasks
    // ----------------
    task automatic stop_test();
        if (miscompares == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // single word transfer; address held until ready, data until ready again
    task automatic ahb_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask,
                          input logic [31:0] exp, input string name);
        logic [31:0] v;
        ahb_xfer(1'b0, a, 32'h0, v);
        chk(name, exp, v & mask);
        chk("bus response", 32'h0, hresp);
    endtask
    // waits for the host to finish a primary or a secondary word
    task automatic wait_cnt(input logic sec);
        logic [7:0] c0;
        int n;
        c0 = sec ? secCnt : priCnt;
        n = 0;
        while ((sec ? secCnt : priCnt) === c0 && n < 1200) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 1200) chk("frame wait", 32'h0, 32'h1);
    endtask
    task automatic sec_op(input logic [15:0] cmd);
        secWord <= cmd;
        priWord <= {priWord[15:1], 1'b1};
        wait_cnt(1'b1);
        priWord <= {priWord[15:1], 1'b0};
    endtask
    // ----------------
    // scenarios
    // ----------------
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(8'h04, 32'h3, 32'h2, "status");
        rd_chk(8'h00, 32'hFFFFFFFF, 32'h0, "ctrl reset");
        ahb_xfer(1'b1, 8'h0C, 32'hFFFF, d);
        rd_chk(8'h0C, 32'hFFFF, 32'h0, "frame count");
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
        adcSample <= 16'h8001;
        priWord <= 16'hA5A4;
        ahb_xfer(1'b1, 8'h00, 32'h1, d);
        rd_chk(8'h00, 32'h1, 32'h1, "ctrl");
        sc = secCnt;
        wait_cnt(1'b0);
        wait_cnt(1'b0);
        chk("adc word", 32'h8001, rxPri);
        chk("dac sample", 32'h52D2, dacSample);
        rd_chk(8'h08, 32'hFFFF, 32'hA5A4, "input word");
        chk("no secondary", sc, secCnt);
        // secondary writes, reads, no-op and overflow clear, two frames each
        for (int i = 0; i < 5; i++) begin
            if (i == 3) begin
                adcFullScale <= 1'b1;
                @(posedge mclk);
                adcFullScale <= 1'b0;
            end
            sec_op(cmdTab[i]);
            rx = rxSec;
            wait_cnt(1'b0);
            chk("sec reply", rxTab[i], rx);
            chk("ctrl reg1", 32'h3C, ctrlReg1);
            chk("ctrl reg2", r2Tab[i], ctrlReg2);
        end
        // envelope sync mode after a fresh reset
        rstn <= 1'b0;
        syncModeStrap <= 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        chk("reg1 reset", 32'h0, ctrlReg1);
        adcSample <= 16'h7FFE;
        ahb_xfer(1'b1, 8'h00, 32'h1, d);
        sec_op(16'h0181);
        rx = rxSec;
        wait_cnt(1'b0);
        chk("env adc word", 32'h7FFE, rxPri);
        chk("env sec reply", 32'h0, rx);
        chk("env reg1", 32'h81, ctrlReg1);
        chk("dac strobes", priCnt, strobeCnt);
        rd_chk(8'h04, 32'h2, 32'h0, "status mode");
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        chk("watchdog", 32'h0, 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
